//--- logic/isam_pkg.sv
/*
 Package for the line activation controller: state codes, INFO encodings,
 timing constants. Assumes a 25 MHz system clock.
*/
package isam_pkg;
    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int unsigned CLOCK_HZ = 25000000;
    localparam int unsigned GUARD_TIME_MS = 32;
    localparam int unsigned GUARD_CYCLES = (CLOCK_HZ / 1000) * GUARD_TIME_MS;
    localparam int unsigned ACTIVITY_WINDOW_BITS = 48;
    localparam int unsigned ACTIVITY_ZEROS = 3;
    localparam int unsigned IDLE_ONES = 128;
    localparam int unsigned STATUS_WIDTH = 8;

    // ----------------------------------------
    // Control register layout
    // ----------------------------------------
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_DIAG = 2'h2;
    localparam int unsigned CTRL_NT_MODE_BIT = 0;
    localparam int unsigned CTRL_CLEAR_DIAG_BIT = 5;
    localparam int unsigned CTRL_ACT_REQ_BIT = 6;
    localparam int unsigned CTRL_DEACT_REQ_BIT = 7;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DIAG_RESET = 8'h00;

    // ----------------------------------------
    // State codes (hi, lo)
    // ----------------------------------------
    localparam logic [1:0] CODE_DEACT = 2'h0;
    localparam logic [1:0] CODE_LOW1 = 2'h1;
    localparam logic [1:0] CODE_PEND_ACT = 2'h2;
    localparam logic [1:0] CODE_ACTIVE = 2'h3;

    typedef enum logic [2:0] {
        INFO_0,
        INFO_1,
        INFO_2,
        INFO_3,
        INFO_4
    } isam_info_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PEND_ACT,
        ST_ACTIVE,
        ST_PEND_DEACT
    } isam_state_type;
endpackage

//--- logic/isam_evt_if.sv
/*
 Interface carrying received-line events from the activity detector
 to the state controller. Assumes one clock domain.
*/
`timescale 1ns/1ns
interface isam_evt_if;
    logic bus_activity;
    logic info0_seen;
    modport source (output bus_activity, output info0_seen);
    modport sink (input bus_activity, input info0_seen);
endinterface

//--- logic/isam_activity.sv
/*
 Bus activity detector on received line bits.
 Assumes bit strobe and bit value already synchronised to clock.
*/
`timescale 1ns/1ns
module isam_activity #(
    parameter int unsigned WINDOW = isam_pkg::ACTIVITY_WINDOW_BITS,
    parameter int unsigned ONES = isam_pkg::IDLE_ONES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic bit_strobe,
    input wire logic bit_value,
    isam_evt_if.source evt
);
    initial begin
        if (WINDOW < 3 || WINDOW > 255 || ONES < 2 || ONES > 255) begin
            $error("isam_activity: bad window or ones count");
        end
    end

    typedef struct packed {
        logic [WINDOW-1:0] hist;
        logic [7:0] ones;
        logic active;
    } isam_act_type;

    isam_act_type s_q;
    isam_act_type s_d;
    logic [7:0] zeros;

    // ----------------------------------------
    // Zero count over the sliding window
    // ----------------------------------------
    always_comb begin
        zeros = 8'h00;
        for (int i = 0; i < WINDOW; i++) begin
            zeros = zeros + {7'h00, ~s_d.hist[i]};
        end
    end

    always_comb begin
        s_d = s_q;
        if (bit_strobe) begin
            s_d.hist = {s_q.hist[WINDOW-2:0], bit_value};
            if (bit_value) begin
                if (s_q.ones != 8'(ONES)) begin
                    s_d.ones = s_q.ones + 8'h01;
                end
            end else begin
                s_d.ones = 8'h00;
            end
        end
        // Ones-fill history so reset alone never fakes activity
        if (s_d.ones == 8'(ONES)) begin
            s_d.active = 1'b0;
        end else if (zeros >= 8'(isam_pkg::ACTIVITY_ZEROS)) begin
            s_d.active = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{hist: '1, ones: 8'h00, active: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign evt.bus_activity = s_q.active;
    assign evt.info0_seen = ~s_q.active;
endmodule

//--- logic/isam_core.sv
/*
 Layer 1 activation controller for a four-wire line transceiver, NT or TE.
 Assumes a framer supplies sync and A-bit indications on this clock, and
 line bits/frame pulse arrive from pins (synchronised here).
*/
// Contract
// - NT: activation request starts INFO2 at next frame pulse.
// - TE: activation request starts INFO1 at next frame pulse.
// - NT answers bus activity with INFO2 without needing sync.
// - NT losing sync returns to sending INFO2.
// - TE losing sync drops INFO3 and sends INFO0.
// - NT codes: 00 G1, 01 G4, 10 G2, 11 G3.
// - TE codes: 00 F3, 01 F6/F8, 10 F4/F5, 11 F7.
// - NT sends INFO0 in G1/G4, INFO2 in G2, INFO4 in G3.
// - Deactivation in G2/G3 starts 32 ms timer, enters G4; exit on INFO0/expiry.
// - NT G2 to G3 on sync; G2/G3 entered only with deactivation clear.
// - Active NT on INFO0 or sync loss returns to G2 sending INFO2.
// - TE sends INFO0 F3, INFO1 F4/F5, INFO3 if synced F6/F8, INFO3 F7.
// - TE deactivation request or INFO0 in F6/F8/F7 leads to F3.
// - States progress without host while deactivation clear; INFO2, INFO4 steps.
// - TE F4 moves to F5 on any received signal; code keeps F4/F5 as one state (10) sending INFO1 until sync.
// - Sync, activity and INFO0 flags distinguish F6/F8 and F4/F5.
// - Deactivated TE answers INFO2 or INFO4 within 100 ms.
// - Synchronised TE answers INFO4 within two frames.
// - Active TE answers INFO0 with INFO0 within 25 ms.
// - Deactivated NT answers INFO1 within 1 s, INFO3 within 500 ms.
// - Activation and deactivation requests are control bits 6 and 7.
// - Bus activity on three zeros in 48 bits, cleared by 128 ones.
// - Synced TE sees INFO4 on A-bit one, INFO2 on A-bit zero.
`timescale 1ns/1ns
module isam_core #(
    parameter int unsigned GUARD_CYCLES = isam_pkg::GUARD_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic system_frame_pulse,
    input wire logic rx_bit_strobe,
    input wire logic rx_bit,
    input wire logic rx_sync,
    input wire logic rx_a_bit,
    output logic [2:0] tx_info,
    output logic state_code_bit_hi,
    output logic state_code_bit_lo,
    output logic tx_a_bit
);
    initial begin
        if (GUARD_CYCLES < 2 || GUARD_CYCLES > 32'h00ffffff) begin
            $error("isam_core: guard timer count out of range");
        end
    end

    // ----------------------------------------
    // State record
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] fp_sync;
        logic [1:0] strobe_sync;
        logic strobe_prev;
        logic [1:0] bit_sync;
        logic fp_prev;
        logic [7:0] control;
        logic [7:0] diag;
        logic [7:0] rdata;
        isam_pkg::isam_state_type state;
        logic [23:0] guard;
        logic guard_run;
        isam_pkg::isam_info_type info;
        logic [1:0] code;
        logic a_out;
    } isam_core_type;

    isam_core_type s_q;
    isam_core_type s_d;
    isam_evt_if evt ();

    logic frame_edge;
    logic nt_mode;
    logic act_req;
    logic deact_req;
    logic guard_done;
    logic [7:0] status;

    isam_activity u_activity (
        .clock(clock),
        .nrst(nrst),
        .bit_strobe(s_q.strobe_sync[1] & ~s_q.strobe_prev),
        .bit_value(s_q.bit_sync[1]),
        .evt(evt)
    );

    // Framer flags come from same-clock logic; pins are synchronised
    assign frame_edge = s_q.fp_sync[1] & ~s_q.fp_prev;
    assign nt_mode = s_q.control[isam_pkg::CTRL_NT_MODE_BIT];
    assign act_req = s_q.control[isam_pkg::CTRL_ACT_REQ_BIT];
    assign deact_req = s_q.control[isam_pkg::CTRL_DEACT_REQ_BIT];
    assign guard_done = s_q.guard_run && (s_q.guard == 24'h000000);
    assign status = {evt.bus_activity, evt.info0_seen, rx_sync, rx_a_bit,
        1'b0, s_q.guard_run, s_q.code};

    always_comb begin
        s_d = s_q;
        s_d.fp_sync = {s_q.fp_sync[0], system_frame_pulse};
        s_d.strobe_sync = {s_q.strobe_sync[0], rx_bit_strobe};
        s_d.bit_sync = {s_q.bit_sync[0], rx_bit};
        s_d.fp_prev = s_q.fp_sync[1];
        // Edge taken after the second stage; the first may still be settling
        s_d.strobe_prev = s_q.strobe_sync[1];

        // ----------------------------------------
        // Register port
        // ----------------------------------------
        if (reg_write) begin
            if (reg_addr == isam_pkg::ADDR_CONTROL) begin
                s_d.control = reg_wdata;
            end else if (reg_addr == isam_pkg::ADDR_DIAG) begin
                s_d.diag = reg_wdata;
            end
        end
        // Test modes could block activation, so held clear while control bit 5 is set
        if (s_q.control[isam_pkg::CTRL_CLEAR_DIAG_BIT]) begin
            s_d.diag = isam_pkg::DIAG_RESET;
        end
        s_d.rdata = 8'h00;
        if (reg_read) begin
            if (reg_addr == isam_pkg::ADDR_CONTROL) begin
                s_d.rdata = s_q.control;
            end else if (reg_addr == isam_pkg::ADDR_STATUS) begin
                s_d.rdata = status;
            end else if (reg_addr == isam_pkg::ADDR_DIAG) begin
                s_d.rdata = s_q.diag;
            end
        end

        // ----------------------------------------
        // Guard timer runs every cycle, not per frame
        // ----------------------------------------
        if (s_q.guard_run && s_q.guard != 24'h000000) begin
            s_d.guard = s_q.guard - 24'h000001;
        end

        // ----------------------------------------
        // State machine, stepped at frame pulses
        // ----------------------------------------
        if (frame_edge) begin
            if (nt_mode) begin
                case (s_q.state)
                    isam_pkg::ST_IDLE: begin
                        if (!deact_req && (act_req || evt.bus_activity)) begin
                            s_d.state = isam_pkg::ST_PEND_ACT;
                        end
                    end
                    isam_pkg::ST_PEND_ACT: begin
                        if (deact_req) begin
                            s_d.state = isam_pkg::ST_PEND_DEACT;
                            s_d.guard_run = 1'b1;
                            s_d.guard = 24'(GUARD_CYCLES - 1);
                        end else if (rx_sync) begin
                            s_d.state = isam_pkg::ST_ACTIVE;
                        end
                    end
                    isam_pkg::ST_ACTIVE: begin
                        if (deact_req) begin
                            s_d.state = isam_pkg::ST_PEND_DEACT;
                            s_d.guard_run = 1'b1;
                            s_d.guard = 24'(GUARD_CYCLES - 1);
                        end else if (!rx_sync || evt.info0_seen) begin
                            s_d.state = isam_pkg::ST_PEND_ACT;
                        end
                    end
                    default: begin
                        if (evt.info0_seen || guard_done) begin
                            s_d.state = isam_pkg::ST_IDLE;
                            s_d.guard_run = 1'b0;
                        end
                    end
                endcase
            end else begin
                case (s_q.state)
                    isam_pkg::ST_IDLE: begin
                        if (!deact_req && rx_sync) begin
                            s_d.state = isam_pkg::ST_PEND_DEACT;
                        end else if (!deact_req && act_req) begin
                            s_d.state = isam_pkg::ST_PEND_ACT;
                        end
                    end
                    isam_pkg::ST_PEND_ACT: begin
                        if (deact_req) begin
                            s_d.state = isam_pkg::ST_IDLE;
                        end else if (rx_sync) begin
                            s_d.state = isam_pkg::ST_PEND_DEACT;
                        end
                    end
                    isam_pkg::ST_PEND_DEACT: begin
                        if (deact_req || evt.info0_seen) begin
                            s_d.state = isam_pkg::ST_IDLE;
                        end else if (rx_sync && rx_a_bit) begin
                            s_d.state = isam_pkg::ST_ACTIVE;
                        end
                    end
                    default: begin
                        if (deact_req || evt.info0_seen) begin
                            s_d.state = isam_pkg::ST_IDLE;
                        end else if (!rx_sync) begin
                            s_d.state = isam_pkg::ST_PEND_DEACT;
                        end
                    end
                endcase
            end

            // Transmitted INFO follows the new state
            s_d.a_out = 1'b0;
            if (nt_mode) begin
                case (s_d.state)
                    isam_pkg::ST_PEND_ACT: s_d.info = isam_pkg::INFO_2;
                    isam_pkg::ST_ACTIVE: begin
                        s_d.info = isam_pkg::INFO_4;
                        s_d.a_out = 1'b1;
                    end
                    default: s_d.info = isam_pkg::INFO_0;
                endcase
            end else begin
                case (s_d.state)
                    isam_pkg::ST_PEND_ACT: s_d.info = isam_pkg::INFO_1;
                    isam_pkg::ST_PEND_DEACT: begin
                        s_d.info = rx_sync ? isam_pkg::INFO_3 : isam_pkg::INFO_0;
                    end
                    isam_pkg::ST_ACTIVE: s_d.info = isam_pkg::INFO_3;
                    default: s_d.info = isam_pkg::INFO_0;
                endcase
            end
        end

        // TE sync loss drops INFO3 without waiting for a frame
        if (!nt_mode && !rx_sync && s_q.info == isam_pkg::INFO_3) begin
            s_d.info = isam_pkg::INFO_0;
        end

        // ----------------------------------------
        // State code
        // ----------------------------------------
        case (s_d.state)
            isam_pkg::ST_PEND_ACT: s_d.code = isam_pkg::CODE_PEND_ACT;
            isam_pkg::ST_ACTIVE: s_d.code = isam_pkg::CODE_ACTIVE;
            isam_pkg::ST_PEND_DEACT: s_d.code = isam_pkg::CODE_LOW1;
            default: s_d.code = isam_pkg::CODE_DEACT;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{fp_sync: 2'h0, strobe_sync: 2'h0, strobe_prev: 1'b0, bit_sync: 2'h3,
                fp_prev: 1'b0, control: isam_pkg::CONTROL_RESET, diag: isam_pkg::DIAG_RESET,
                rdata: 8'h00, state: isam_pkg::ST_IDLE, guard: 24'h000000,
                guard_run: 1'b0, info: isam_pkg::INFO_0,
                code: isam_pkg::CODE_DEACT, a_out: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign tx_info = s_q.info;
    assign state_code_bit_hi = s_q.code[1];
    assign state_code_bit_lo = s_q.code[0];
    assign tx_a_bit = s_q.a_out;
endmodule

//--- bench/isam_core_assertions.sv
/*
 Port checker for the line activation controller.
 Assumes it is bound to isam_core and sees only its ports.
*/
`timescale 1ns/1ns
module isam_core_assertions #(
    parameter int unsigned GUARD_CYCLES = isam_pkg::GUARD_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic system_frame_pulse,
    input wire logic rx_bit_strobe,
    input wire logic rx_bit,
    input wire logic rx_sync,
    input wire logic rx_a_bit,
    input wire logic [2:0] tx_info,
    input wire logic state_code_bit_hi,
    input wire logic state_code_bit_lo,
    input wire logic tx_a_bit
);
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    logic nt_q;
    logic [3:0] age_q;
    logic [23:0] hold_q;
    logic [1:0] code;
    assign code = {state_code_bit_hi, state_code_bit_lo};
    // Mode mirrored from writes; only switched while deactivated
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            nt_q <= 1'b0;
            age_q <= 4'hf;
            hold_q <= 24'h000000;
        end else begin
            if (reg_write && reg_addr == isam_pkg::ADDR_CONTROL) begin
                nt_q <= reg_wdata[0];
            end
            age_q <= system_frame_pulse ? 4'h0 : (age_q == 4'hf ? age_q : age_q + 4'h1);
            hold_q <= (nt_q && code == 2'h1) ? hold_q + 24'h000001 : 24'h000000;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_ask(logic m);
        reg_write && reg_addr == 2'h0 && reg_wdata[0] == m && reg_wdata[7:6] == 2'b01
            && code == 2'h0;
    endsequence
    a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 8'h00) else $error("read data not zero");
    a_status_code_echo: assert property (reg_read && reg_addr == 2'h1 |=> reg_rdata[1:0] == $past(code) && !reg_rdata[3]) else $error("status code wrong");
    a_abit_with_info4: assert property (tx_a_bit == (tx_info == 3'h4)) else $error("a bit mismatch");
    a_nt_info_map: assert property (nt_q |-> tx_info == (code == 2'h3 ? 3'h4 : (code == 2'h2 ? 3'h2 : 3'h0))) else $error("nt info wrong");
    a_te_info_map: assert property (!nt_q && !code[0] |-> tx_info == (code == 2'h2 ? 3'h1 : 3'h0)) else $error("te info wrong");
    // In F7 a sync loss drops INFO3 before the next frame step moves the code
    a_te_info_active: assert property (!nt_q && code == 2'h3 |->
        (tx_info == 3'h3 || tx_info == 3'h0)
        && ($past(tx_info) != 3'h3 || tx_info == 3'h3 || !$past(rx_sync))) else $error("te active info wrong");
    a_te_info3_synced: assert property (!nt_q && code == 2'h1 && tx_info == 3'h3 |-> $past(rx_sync)) else $error("info3 unsynced");
    a_te_sync_drop: assert property (!nt_q && tx_info == 3'h3 && !rx_sync |=> tx_info == 3'h0) else $error("info3 kept");
    a_step_at_frame: assert property ($changed(code) |-> age_q <= 4'h6) else $error("step off frame");
    a_guard_bound: assert property (hold_q < GUARD_CYCLES + 40) else $error("guard overrun");
    a_nt_act_start: assert property (s_ask(1'b1) |-> ##[1:24] code == 2'h2) else $error("nt no start");
    a_te_act_start: assert property (s_ask(1'b0) |-> ##[1:24] code == 2'h2) else $error("te no start");
endmodule
bind isam_core isam_core_assertions #(.GUARD_CYCLES(GUARD_CYCLES)) u_chk (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .system_frame_pulse(system_frame_pulse), .rx_bit_strobe(rx_bit_strobe),
    .rx_bit(rx_bit), .rx_sync(rx_sync), .rx_a_bit(rx_a_bit), .tx_info(tx_info),
    .state_code_bit_hi(state_code_bit_hi), .state_code_bit_lo(state_code_bit_lo),
    .tx_a_bit(tx_a_bit));

//--- bench/isam_far_end.sv
/*
 Remote transceiver model: line bits and framer flags.
 Assumes send_kind 0 silent, 1 unframed signal, 2 framed A=0, 3 framed A=1.
*/
`timescale 1ns/1ns
module isam_far_end (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [1:0] send_kind,
    output logic rx_bit_strobe,
    output logic rx_bit,
    output logic rx_sync,
    output logic rx_a_bit
);
    logic [3:0] div_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end
    // One bit every four clocks; marks alternate while sending
    assign rx_bit_strobe = div_q[1];
    assign rx_bit = (send_kind == 2'h0) | div_q[2];
    assign rx_sync = send_kind[1];
    // A-bit means nothing out of frame, so it wanders
    assign rx_a_bit = send_kind[1] ? send_kind[0] : div_q[0];
endmodule

//--- bench/tb_isam_core.sv
/*
 Testbench for the activation controller, NT and TE modes.
 Assumes 25 MHz clock and frame pulse every 16 clocks.
*/
`timescale 1ns/1ns
module tb_isam_core;
    localparam int unsigned GUARD = 50;
    logic clock, nrst, reg_write, reg_read;
    logic system_frame_pulse = 1'b0;
    logic [1:0] reg_addr, send_kind;
    logic [7:0] reg_wdata, d;
    logic [3:0] fcnt = 4'h0;
    wire logic [7:0] reg_rdata;
    wire logic [2:0] tx_info;
    wire logic hi, lo, tx_a_bit, rx_bit_strobe, rx_bit, rx_sync, rx_a_bit;
    int miscompares = 0;
    int samples_checked = 0;
    isam_core #(.GUARD_CYCLES(GUARD)) dut_u (.clock(clock), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .system_frame_pulse(system_frame_pulse), .rx_bit_strobe(rx_bit_strobe),
        .rx_bit(rx_bit), .rx_sync(rx_sync), .rx_a_bit(rx_a_bit), .tx_info(tx_info),
        .state_code_bit_hi(hi), .state_code_bit_lo(lo), .tx_a_bit(tx_a_bit));
    isam_far_end far_u (.clock(clock), .nrst(nrst), .send_kind(send_kind),
        .rx_bit_strobe(rx_bit_strobe), .rx_bit(rx_bit), .rx_sync(rx_sync),
        .rx_a_bit(rx_a_bit));
    // ----------------------------------------
    // Clock, frame pulse, watchdog
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        fcnt <= fcnt + 4'h1;
        system_frame_pulse <= (fcnt == 4'hf);
    end
    initial begin
        #(40 * 12000);
        miscompares++;
        conclude();
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        v = reg_rdata;
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for a state, then both code and INFO compared
    task automatic wait_st(input logic [1:0] c, input logic [2:0] i, input int lim);
        int n;
        n = 0;
        // Outputs looked at on falling edges only, where they are settled
        @(negedge clock);
        while (n < lim && !({hi, lo} === c && tx_info === i)) begin
            @(negedge clock);
            n++;
        end
        check8({3'h0, tx_info, hi, lo}, {3'h0, i, c});
        @(posedge clock);
    endtask
    task automatic conclude();
        $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {nrst, reg_write, reg_read} = 3'h0;
        {reg_addr, send_kind, reg_wdata} = 12'h000;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        wait_st(2'h0, 3'h0, 1);
        rd(2'h0, d); check8(d, isam_pkg::CONTROL_RESET);
        rd(2'h3, d); check8(d, 8'h00);
        wr(2'h0, 8'h41); wait_st(2'h2, 3'h2, 40);
        send_kind <= 2'h2; wait_st(2'h3, 3'h4, 40);
        send_kind <= 2'h1; wait_st(2'h2, 3'h2, 40);
        send_kind <= 2'h2; wait_st(2'h3, 3'h4, 40);
        wr(2'h0, 8'h81); wait_st(2'h1, 3'h0, 40);
        rd(2'h1, d); check8({7'h00, d[2]}, 8'h01);
        wait_st(2'h0, 3'h0, GUARD + 40);
        wr(2'h0, 8'h01); send_kind <= 2'h1; wait_st(2'h2, 3'h2, 300);
        // Second reset returns to the terminal side
        send_kind <= 2'h0; nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        wait_st(2'h0, 3'h0, 1);
        wr(2'h0, 8'h40); wait_st(2'h2, 3'h1, 40);
        // Three marks in 48 bits fit in under 200 clocks
        send_kind <= 2'h1; repeat (300) @(posedge clock);
        rd(2'h1, d); check8({d[7:6], d[1:0]}, 8'h0a);
        send_kind <= 2'h2; wait_st(2'h1, 3'h3, 60);
        rd(2'h1, d); check8({d[6:5], d[1:0]}, 8'h05);
        send_kind <= 2'h3; wait_st(2'h3, 3'h3, 40);
        send_kind <= 2'h1; wait_st(2'h1, 3'h0, 40);
        rd(2'h1, d); check8({d[5], d[1:0]}, 8'h01);
        send_kind <= 2'h3; wait_st(2'h3, 3'h3, 80);
        wr(2'h0, 8'h00); send_kind <= 2'h0; wait_st(2'h0, 3'h0, 800);
        wr(2'h0, 8'h40); wait_st(2'h2, 3'h1, 40);
        wr(2'h0, 8'h80); wait_st(2'h0, 3'h0, 40);
        wr(2'h0, 8'h20); wr(2'h2, 8'h5a); rd(2'h2, d); check8(d, 8'h00);
        wr(2'h0, 8'h00); wr(2'h2, 8'h5a); rd(2'h2, d); check8(d, 8'h5a);
        conclude();
    end
endmodule
